// ### core/txs_slice.v
// transmit slice: serializer, tristate select and output delay line
`timescale 1ns/100ps
`include "txs_map.vh"
module txs_slice (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_data,
  input wire i_data_valid,
  output wire o_data_ready,
  input wire i_width4,
  input wire i_tri,
  input wire i_per_bit_tristate_in,
  input wire i_tristate_source_select,
  output wire o_ser,
  output wire o_tri_out,
  input wire i_dly_clk_en,
  input wire i_delay_reset,
  input wire [1:0] i_dly_mode,
  input wire i_dly_step_en,
  input wire i_dly_step_up,
  input wire i_dly_load,
  input wire [8:0] i_delay_load_value,
  output wire [8:0] o_delay_tap
);
  reg [1:0] rst_sync_reg;
  reg [1:0] dly_rst_sync_reg;
  reg [7:0] shift_reg;
  reg [3:0] left_reg;
  reg ser_reg;
  reg tri_bit_reg;
  reg [8:0] tap_reg;
  reg [8:0] tap_next;
  reg [7:0] shift_next;
  reg [3:0] left_next;
  reg ser_next;
  reg [3:0] width;
  reg tri_mux;
  wire rst_tx;
  wire rst_dly;
  wire [7:0] buf_data;
  wire buf_valid;
  wire take;
  wire [7:0] load_shift;
  wire [7:0] run_shift;
  wire dly_load_now;
  wire dly_step_now;

  // bits above the word width are never shifted out
  function keep_bit;
    input integer idx;
    input narrow;
    begin
      keep_bit = !(narrow && (idx >= `TXS_HALF_W));
    end
  endfunction

  // tap counter wraps both ways, no saturation
  function [8:0] tap_step;
    input [8:0] tap;
    input up;
    begin
      if (up) begin
        tap_step = (tap == `TXS_TAP_MAX) ? `TXS_TAP_ZERO : tap + 9'h001;
      end else begin
        tap_step = (tap == `TXS_TAP_ZERO) ? `TXS_TAP_MAX : tap - 9'h001;
      end
    end
  endfunction

  function mode_is;
    input [1:0] mode;
    input [1:0] code;
    begin
      mode_is = (mode == code);
    end
  endfunction

  // release after two edges so the shifter never starts on a runt edge
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_sync_reg <= 2'b11;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b0};
    end
  end
  assign rst_tx = rst_sync_reg[1];

  // delay reset releases only on delay clock enables
  always @(posedge i_sys_clk or posedge i_delay_reset) begin
    if (i_delay_reset) begin
      dly_rst_sync_reg <= 2'b11;
    end else if (i_dly_clk_en) begin
      dly_rst_sync_reg <= {dly_rst_sync_reg[0], 1'b0};
    end
  end
  assign rst_dly = dly_rst_sync_reg[1];

  // a stall of the shifter leaves words parked here, never dropped
  txs_buf2 u_buf (
    .i_sys_clk(i_sys_clk),
    .i_rst(rst_tx),
    .i_in_data(i_data),
    .i_in_valid(i_data_valid),
    .o_in_ready(o_data_ready),
    .o_out_data(buf_data),
    .o_out_valid(buf_valid),
    .i_out_ready(take)
  );

  always @* begin
    case (i_width4)
      1'b1: begin
        width = `TXS_CNT_HALF;
      end
      default: begin
        width = `TXS_CNT_FULL;
      end
    endcase
  end

  // next word is taken as the last bit of the running one goes out
  assign take = buf_valid && (left_reg <= `TXS_CNT_ONE);

  // upper nibble is masked at width four, whatever the fabric drives there
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_shift
      assign load_shift[g] = keep_bit(g + 1, i_width4) ? buf_data[g + 1] : 1'b0;
      assign run_shift[g] = shift_reg[g + 1];
    end
  endgenerate
  assign load_shift[7] = 1'b0;
  assign run_shift[7] = 1'b0;

  // bit clock is the system clock; lsb first, back to back words
  always @* begin
    ser_next = ser_reg;
    shift_next = shift_reg;
    left_next = left_reg;
    if (take) begin
      ser_next = buf_data[0];
      shift_next = load_shift;
      left_next = width;
    end else if (left_reg > `TXS_CNT_ONE) begin
      ser_next = shift_reg[0];
      shift_next = run_shift;
      left_next = left_reg - `TXS_CNT_ONE;
    end else if (left_reg == `TXS_CNT_ONE) begin
      left_next = `TXS_CNT_ZERO;
    end
  end

  always @(posedge i_sys_clk or posedge rst_tx) begin
    if (rst_tx) begin
      ser_reg <= `TXS_OUT_INIT;
      shift_reg <= 8'h00;
      left_reg <= `TXS_CNT_ZERO;
      tri_bit_reg <= `TXS_TRI_INIT;
    end else begin
      tri_bit_reg <= ~i_per_bit_tristate_in;
      ser_reg <= ser_next;
      shift_reg <= shift_next;
      left_reg <= left_next;
    end
  end
  assign o_ser = ser_reg;

  // direct input is combinational and gates the whole stream
  always @* begin
    case (i_tristate_source_select)
      1'b0: begin
        tri_mux = i_tri;
      end
      1'b1: begin
        tri_mux = tri_bit_reg;
      end
      default: begin
        tri_mux = `TXS_TRI_INIT;
      end
    endcase
  end
  assign o_tri_out = tri_mux;

  // in load mode, load wins over a step if both are raised
  assign dly_load_now = mode_is(i_dly_mode, `TXS_MODE_LOAD) && i_dly_load;
  assign dly_step_now = !mode_is(i_dly_mode, `TXS_MODE_FIXED) && i_dly_step_en;

  always @* begin
    tap_next = tap_reg;
    if (dly_load_now) begin
      tap_next = i_delay_load_value;
    end else if (dly_step_now) begin
      tap_next = tap_step(tap_reg, i_dly_step_up);
    end
  end

  // inversion of the delay clock is the enable source's business
  always @(posedge i_sys_clk or posedge rst_dly) begin
    if (rst_dly) begin
      tap_reg <= `TXS_DELAY_INIT;
    end else if (i_dly_clk_en) begin
      tap_reg <= tap_next;
    end
  end
  assign o_delay_tap = tap_reg;
endmodule

// ### core/txs_map.vh
// constants for the transmit serializer slice
`ifndef TXS_MAP_VH
`define TXS_MAP_VH
`define TXS_WORD_W 8
`define TXS_HALF_W 4
`define TXS_TAP_W 9
`define TXS_TAP_MAX 9'h1ff
`define TXS_TAP_ZERO 9'h000
`define TXS_DELAY_INIT 9'h000
`define TXS_OUT_INIT 1'b0
`define TXS_TRI_INIT 1'b1
`define TXS_CNT_W 4
`define TXS_CNT_ONE 4'h1
`define TXS_CNT_ZERO 4'h0
`define TXS_CNT_FULL 4'h8
`define TXS_CNT_HALF 4'h4
`define TXS_MODE_W 2
`define TXS_MODE_FIXED 2'h0
`define TXS_MODE_A 2'h1
`define TXS_MODE_LOAD 2'h2
`endif

// ### core/txs_buf2.v
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/100ps
module txs_buf2 (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_in_data,
  input wire i_in_valid,
  output wire o_in_ready,
  output wire [7:0] o_out_data,
  output wire o_out_valid,
  input wire i_out_ready
);
  reg [7:0] mem_reg [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  assign o_in_ready = (count_reg != 2'h2);
  assign o_out_valid = (count_reg != 2'h0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= i_in_data;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule

// ### test/txs_monitor.sv
// port assertions for the transmit slice
`timescale 1ns/100ps
module txs_monitor (
  input wire i_sys_clk, i_rst, i_tri, i_per_bit_tristate_in, i_tristate_source_select,
  input wire o_ser, o_tri_out, i_dly_clk_en, i_delay_reset, i_dly_step_en, i_dly_step_up,
  input wire i_dly_load,
  input wire [1:0] i_dly_mode,
  input wire [8:0] i_delay_load_value, o_delay_tap
);
  reg [1:0] n_reg;
  // taps count only once the delay reset has fully let go
  wire go = i_dly_clk_en && n_reg == 2'h3;
  wire st = go && i_dly_step_en && i_dly_mode == 2'h1;
  always @(posedge i_sys_clk or posedge i_delay_reset) begin
    if (i_delay_reset) n_reg <= 2'h0;
    else if (i_dly_clk_en && !go) n_reg <= n_reg + 2'h1;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_delay_reset);
  tri_direct_a: assert property (disable iff (i_rst)
    !i_tristate_source_select |-> o_tri_out == i_tri) else $error("tri direct");
  tri_bit_a: assert property (disable iff (i_rst)
    i_tristate_source_select && !$past(i_rst, 3) |-> o_tri_out == !$past(i_per_bit_tristate_in))
    else $error("tri per bit");
  ser_init_a: assert property (disable iff (1'b0) i_rst |-> !o_ser) else $error("ser init");
  tap_init_a: assert property (disable iff (1'b0)
    i_delay_reset |-> o_delay_tap == 9'h000) else $error("tap init");
  tap_hold_a: assert property (!i_dly_clk_en |=> $stable(o_delay_tap)) else $error("tap hold");
  tap_up_a: assert property (st && i_dly_step_up |=> o_delay_tap == $past(o_delay_tap) + 9'h001)
    else $error("tap up");
  tap_down_a: assert property (st && !i_dly_step_up |=> o_delay_tap == $past(o_delay_tap) - 9'h001)
    else $error("tap down");
  tap_load_a: assert property (go && i_dly_load && i_dly_mode == 2'h2
    |=> o_delay_tap == $past(i_delay_load_value)) else $error("tap load");
  cover property (st);
  cover property (go && i_dly_load);
  cover property (i_tristate_source_select && !i_per_bit_tristate_in);
endmodule
bind txs_slice txs_monitor u_mon (.*);

// ### test/txs_pad_model.sv
// output buffer model; a released pad shows the inverse of its last level
`timescale 1ns/100ps
module txs_pad_model (input wire i_sys_clk, i_ser, i_tri, output logic o_pad);
  logic last_reg = 1'b0;
  always @(posedge i_sys_clk) if (!i_tri) last_reg <= i_ser;
  assign o_pad = i_tri ? ~last_reg : i_ser;
endmodule

// ### test/tb_tx_serializer_tristate_delay.sv
// self-checking bench for the transmit slice
`timescale 1ns/100ps
module tb_tx_serializer_tristate_delay;
  logic i_sys_clk = 1'b0, i_rst = 1'b0, i_delay_reset = 1'b0, i_data_valid = 1'b0, i_width4 = 1'b0;
  logic i_tri = 1'b0, i_per_bit_tristate_in = 1'b1, i_tristate_source_select = 1'b0;
  logic i_dly_clk_en = 1'b0, i_dly_step_en = 1'b0, i_dly_step_up = 1'b0, i_dly_load = 1'b0;
  logic [7:0] i_data = 8'h00;
  logic [1:0] i_dly_mode = 2'h0;
  logic [8:0] i_delay_load_value = 9'h155, o_delay_tap;
  logic o_data_ready, o_ser, o_tri_out, pad;
  int num_errors = 0, total_checks = 0, cyc = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  txs_slice u_dut (.*);
  txs_pad_model u_pad (.i_sys_clk(i_sys_clk), .i_ser(o_ser), .i_tri(o_tri_out), .o_pad(pad));
  task test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      test_done;
    end
  end
  task chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge i_sys_clk);
    #2;
  endtask
  task push(input logic [7:0] d);
    i_data = d;
    i_data_valid = 1'b1;
    while (o_data_ready !== 1'b1) tick;
    tick;
  endtask
  // three back-to-back words; the third fills the buffer
  task t_stream(input logic [23:0] w, input logic w4);
    logic [23:0] b;
    i_width4 = w4;
    b = w4 ? {12'h000, w[19:16], w[11:8], w[3:0]} : w;
    push(w[7:0]);
    push(w[15:8]);
    chk(pad, b[0]);
    push(w[23:16]);
    i_data_valid = 1'b0;
    chk(o_data_ready, 1'b0);
    for (int i = 1; i < (w4 ? 12 : 24); i++) begin
      chk(pad, b[i]);
      tick;
    end
  endtask
  task t_tri;
    i_tri = 1'b1;
    tick;
    chk(o_tri_out, 1'b1);
    i_tristate_source_select = 1'b1;
    i_per_bit_tristate_in = 1'b0;
    tick;
    chk(o_tri_out, 1'b1);
    i_per_bit_tristate_in = 1'b1;
    tick;
    chk(o_tri_out, 1'b0);
  endtask
  task pulse(input logic [1:0] m, input logic [2:0] c, input logic [8:0] exp);
    {i_dly_step_en, i_dly_step_up, i_dly_load} = c;
    i_dly_mode = m;
    i_dly_clk_en = 1'b1;
    tick;
    i_dly_clk_en = 1'b0;
    chk(o_delay_tap, exp);
    tick;
  endtask
  initial begin
    #1;
    i_rst = 1'b1;
    i_delay_reset = 1'b1;
    repeat (2) tick;
    chk(o_ser, 1'b0);
    i_rst = 1'b0;
    i_delay_reset = 1'b0;
    repeat (3) tick;
    t_stream(24'h3c_a581, 1'b0);
    t_stream(24'h06_090e, 1'b1);
    t_tri;
    repeat (3) pulse(2'h0, 3'b110, 9'h000);
    pulse(2'h2, 3'b001, 9'h155);
    pulse(2'h1, 3'b100, 9'h154);
    i_delay_load_value = 9'h1ff;
    pulse(2'h2, 3'b001, 9'h1ff);
    pulse(2'h1, 3'b110, 9'h000);
    pulse(2'h1, 3'b100, 9'h1ff);
    pulse(2'h2, 3'b010, 9'h1ff);
    pulse(2'h2, 3'b110, 9'h000);
    tick;
    chk(o_delay_tap, 9'h000);
    pulse(2'h1, 3'b100, 9'h1ff);
    i_delay_reset = 1'b1;
    #1 chk(o_delay_tap, 9'h000);
    test_done;
  end
endmodule
